// file: core/conv_seq_map.vh
`ifndef CONV_SEQ_MAP_VH
`define CONV_SEQ_MAP_VH

// register byte offsets
`define OFS_DEV_CFG1 8'h00
`define OFS_SENS_CFG1 8'h04
`define OFS_TEMP_CFG 8'h08
`define OFS_INT_CFG1 8'h0C
`define OFS_DEV_CFG2 8'h10
`define OFS_THR_X 8'h14
`define OFS_THR_Y 8'h18
`define OFS_THR_Z 8'h1C
`define OFS_TRIG 8'h20
`define OFS_STATUS 8'h24
`define OFS_RES_T 8'h28
`define OFS_RES_X 8'h2C
`define OFS_RES_Y 8'h30
`define OFS_RES_Z 8'h34

// device config 1: averaging factor field
`define AVG_LSB 2
`define AVG_MSB 4
`define AVG_MAX 3'h5
// device config 2: operating mode field
`define MODE_LSB 0
`define MODE_MSB 1
`define MODE_TRIG 2'h0
`define MODE_WAKE 2'h3
`define MODE_CONT 2'h2
// sensor config 1: axis enable field
`define CHEN_LSB 4
`define CHEN_MSB 7
`define CHEN_XZX 4'hB
`define CHEN_YZY 4'hC
// temperature config: enable bit
`define TEN_BIT 0
// int config 1: result int enable, threshold int enable, direction, hysteresis
`define INT_RES_BIT 7
`define INT_THR_BIT 6
`define DIR_BIT 3
`define HYST_BIT 2

// reset values
`define RST_DEV_CFG1 8'h00
`define RST_SENS_CFG1 8'h00
`define RST_TEMP_CFG 8'h00
`define RST_INT_CFG1 8'h00
`define RST_DEV_CFG2 8'h00
`define RST_THR 16'h0000

// timing
`define CLK_HZ 20000000
`define SAMPLE_NS 1000
`define SAMPLE_CYC ((`SAMPLE_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define WAKE_US 10000
`define WAKE_CYC (`WAKE_US * (`CLK_HZ / 1000000))

`endif

// file: core/conv_seq.v
`include "conv_seq_map.vh"
`timescale 1ns/1ps
`default_nettype none

module conv_seq #(
    parameter integer SAMPLE_CYC = `SAMPLE_CYC,
    parameter integer WAKE_CYC = `WAKE_CYC
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire i_int_in,
    output wire o_int_out,
    output wire o_int_oe,
    output wire o_sample_req,
    output wire [1:0] o_sample_ch,
    input wire i_sample_valid,
    input wire [15:0] i_sample_data
);
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_REQ = 5'h02;
    localparam [4:0] S_WAIT = 5'h04;
    localparam [4:0] S_STORE = 5'h08;
    localparam [4:0] S_SLEEP = 5'h10;
    localparam [1:0] CH_T = 2'h0;
    localparam [1:0] CH_X = 2'h1;
    localparam [1:0] CH_Y = 2'h2;
    localparam [1:0] CH_Z = 2'h3;

    reg [7:0] dev_cfg1_q;
    reg [7:0] sens_cfg1_q;
    reg [7:0] temp_cfg_q;
    reg [7:0] int_cfg1_q;
    reg [7:0] dev_cfg2_q;
    reg [15:0] thr_q [0:2];
    reg [15:0] res_q [0:3];
    reg [4:0] state_q;
    reg [2:0] step_q;
    reg [5:0] avg_cnt_q;
    reg [20:0] acc_q;
    reg [23:0] timer_q;
    reg busy_q;
    reg int_low_q;
    reg [2:0] hit_q;
    reg [2:0] inside_q;
    reg int_s1_q;
    reg int_s2_q;
    reg int_s3_q;
    reg cmd_trig_q;

    wire apb_wr = i_psel & i_penable & i_pwrite;
    wire apb_rd_ack = i_psel & i_penable & ~i_pwrite;
    wire [1:0] mode = dev_cfg2_q[`MODE_MSB:`MODE_LSB];
    wire [3:0] axis_channel_enable = sens_cfg1_q[`CHEN_MSB:`CHEN_LSB];
    wire [2:0] avg_sel = (dev_cfg1_q[`AVG_MSB:`AVG_LSB] > `AVG_MAX) ? `AVG_MAX :
        dev_cfg1_q[`AVG_MSB:`AVG_LSB];
    wire threshold_direction_select = int_cfg1_q[`DIR_BIT];
    wire threshold_hysteresis_select = int_cfg1_q[`HYST_BIT];
    wire x_z_x_sampling_order = (axis_channel_enable == `CHEN_XZX);
    wire y_z_y_sampling_order = (axis_channel_enable == `CHEN_YZY);
    wire pin_fall = int_s3_q & ~int_s2_q & ~o_int_oe;
    wire trig_evt = cmd_trig_q | pin_fall;
    wire [5:0] avg_n = 6'h01 << avg_sel;

    // channel for each sequence step; step 0 temperature, 1..3 axes
    reg [1:0] ch_d;
    reg step_en_d;
    always @* begin
        ch_d = CH_T;
        step_en_d = 1'b0;
        if (x_z_x_sampling_order || y_z_y_sampling_order) begin
            case (step_q)
                3'h0: begin
                    ch_d = CH_T;
                    step_en_d = temp_cfg_q[`TEN_BIT];
                end
                3'h1: begin
                    ch_d = x_z_x_sampling_order ? CH_X : CH_Y;
                    step_en_d = 1'b1;
                end
                3'h2: begin
                    ch_d = CH_Z;
                    step_en_d = 1'b1;
                end
                3'h3: begin
                    ch_d = x_z_x_sampling_order ? CH_X : CH_Y;
                    step_en_d = 1'b1;
                end
                default: begin
                    ch_d = CH_T;
                    step_en_d = 1'b0;
                end
            endcase
        end else begin
            case (step_q)
                3'h0: begin
                    ch_d = CH_T;
                    step_en_d = temp_cfg_q[`TEN_BIT];
                end
                3'h1: begin
                    ch_d = CH_X;
                    step_en_d = axis_channel_enable[0];
                end
                3'h2: begin
                    ch_d = CH_Y;
                    step_en_d = axis_channel_enable[1];
                end
                3'h3: begin
                    ch_d = CH_Z;
                    step_en_d = axis_channel_enable[2];
                end
                default: begin
                    ch_d = CH_T;
                    step_en_d = 1'b0;
                end
            endcase
        end
    end

    // accumulator holds every sample of the step, sign extended
    wire [20:0] acc_sum = acc_q + {{5{i_sample_data[15]}}, i_sample_data};
    wire [15:0] avg_val = acc_q[15 + avg_sel -: 16];

    // limit-cross compare per axis, signed results
    function hit_fn;
        input [15:0] val;
        input [15:0] thr;
        input dir;
        input hyst;
        reg signed [16:0] v;
        reg signed [16:0] t;
        reg outside;
        begin
            v = {val[15], val};
            t = {thr[15], thr};
            outside = (v > t) || (v < -t);
            case ({hyst, dir})
                2'b00: hit_fn = v > t;
                2'b01: hit_fn = v < t;
                2'b10: hit_fn = outside;
                2'b11: hit_fn = ~outside;
                default: hit_fn = 1'b0;
            endcase
        end
    endfunction

    // hits including the axis stored this cycle, so the last axis counts too
    wire store_ok = state_q == S_STORE && step_en_d && avg_cnt_q == avg_n;
    wire cur_hit = store_ok && ch_d != CH_T && int_cfg1_q[`INT_THR_BIT] &&
        hit_fn(avg_val, thr_q[ch_d - 2'h1], threshold_direction_select,
        threshold_hysteresis_select);
    wire [2:0] hit_d = hit_q | ({2'b00, cur_hit} << (ch_d - 2'h1));

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            int_s1_q <= 1'b1;
            int_s2_q <= 1'b1;
            int_s3_q <= 1'b1;
        end else begin
            int_s1_q <= i_int_in;
            int_s2_q <= int_s1_q;
            int_s3_q <= int_s2_q;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dev_cfg1_q <= `RST_DEV_CFG1;
            sens_cfg1_q <= `RST_SENS_CFG1;
            temp_cfg_q <= `RST_TEMP_CFG;
            int_cfg1_q <= `RST_INT_CFG1;
            dev_cfg2_q <= `RST_DEV_CFG2;
            thr_q[0] <= `RST_THR;
            thr_q[1] <= `RST_THR;
            thr_q[2] <= `RST_THR;
            cmd_trig_q <= 1'b0;
        end else begin
            cmd_trig_q <= 1'b0;
            if (state_q == S_STORE && step_q == 3'h3 && mode == `MODE_WAKE && (|hit_d))
                dev_cfg2_q[`MODE_MSB:`MODE_LSB] <= `MODE_TRIG;
            if (apb_wr) begin
                case (i_paddr)
                    `OFS_DEV_CFG1: dev_cfg1_q <= i_pwdata[7:0];
                    `OFS_SENS_CFG1: sens_cfg1_q <= i_pwdata[7:0];
                    `OFS_TEMP_CFG: temp_cfg_q <= i_pwdata[7:0];
                    `OFS_INT_CFG1: int_cfg1_q <= i_pwdata[7:0];
                    `OFS_DEV_CFG2: dev_cfg2_q <= i_pwdata[7:0];
                    `OFS_THR_X: thr_q[0] <= i_pwdata[15:0];
                    `OFS_THR_Y: thr_q[1] <= i_pwdata[15:0];
                    `OFS_THR_Z: thr_q[2] <= i_pwdata[15:0];
                    `OFS_TRIG: cmd_trig_q <= i_pwdata[0];
                    default: cmd_trig_q <= 1'b0;
                endcase
            end
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= S_IDLE;
            step_q <= 3'h0;
            avg_cnt_q <= 6'h00;
            acc_q <= 21'h000000;
            timer_q <= 24'h000000;
            busy_q <= 1'b0;
            hit_q <= 3'h0;
            inside_q <= 3'h0;
            res_q[0] <= 16'h0000;
            res_q[1] <= 16'h0000;
            res_q[2] <= 16'h0000;
            res_q[3] <= 16'h0000;
        end else begin
            case (state_q)
                S_IDLE: begin
                    step_q <= 3'h0;
                    acc_q <= 21'h000000;
                    avg_cnt_q <= 6'h00;
                    hit_q <= 3'h0;
                    busy_q <= 1'b0;
                    if (mode == `MODE_CONT ||
                        (mode == `MODE_TRIG && trig_evt) || mode == `MODE_WAKE) begin
                        busy_q <= 1'b1;
                        state_q <= S_REQ;
                    end
                end
                S_REQ: begin
                    if (step_en_d) begin
                        state_q <= S_WAIT;
                    end else if (step_q == 3'h3) begin
                        state_q <= S_STORE;
                    end else begin
                        step_q <= step_q + 3'h1;
                    end
                end
                S_WAIT: begin
                    if (i_sample_valid) begin
                        acc_q <= acc_sum;
                        avg_cnt_q <= avg_cnt_q + 6'h01;
                        if (avg_cnt_q + 6'h01 == avg_n) begin
                            state_q <= S_STORE;
                        end else begin
                            state_q <= S_REQ;
                        end
                    end
                end
                S_STORE: begin
                    if (store_ok)
                        res_q[ch_d] <= avg_val;
                    hit_q <= hit_d;
                    acc_q <= 21'h000000;
                    avg_cnt_q <= 6'h00;
                    if (step_q == 3'h3) begin
                        inside_q <= hit_d;
                        if (mode == `MODE_WAKE && hit_d == 3'h0) begin
                            timer_q <= WAKE_CYC[23:0];
                            state_q <= S_SLEEP;
                        end else begin
                            state_q <= S_IDLE;
                        end
                    end else begin
                        step_q <= step_q + 3'h1;
                        state_q <= S_REQ;
                    end
                end
                S_SLEEP: begin
                    if (mode != `MODE_WAKE)
                        state_q <= S_IDLE;
                    else if (timer_q == 24'h000000)
                        state_q <= S_IDLE;
                    else
                        timer_q <= timer_q - 24'h000001;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // pin drive: low for SAMPLE_CYC + 1 cycles after a completed sequence, if result int is enabled or a threshold hit
    reg [15:0] pulse_q;
    wire seq_done = state_q == S_STORE && step_q == 3'h3;
    wire fire = seq_done && ((int_cfg1_q[`INT_RES_BIT]) ||
        (int_cfg1_q[`INT_THR_BIT] && (|hit_d)));
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            int_low_q <= 1'b0;
            pulse_q <= 16'h0000;
        end else if (fire) begin
            int_low_q <= 1'b1;
            pulse_q <= SAMPLE_CYC[15:0];
        end else if (pulse_q != 16'h0000) begin
            pulse_q <= pulse_q - 16'h0001;
        end else begin
            int_low_q <= 1'b0;
        end
    end

    assign o_int_out = 1'b0;
    assign o_int_oe = int_low_q;
    // held until the answer, low at least a cycle between samples
    assign o_sample_req = (state_q == S_WAIT);
    assign o_sample_ch = ch_d;

    reg [31:0] rdata_d;
    always @* begin
        case (i_paddr)
            `OFS_DEV_CFG1: rdata_d = {24'h000000, dev_cfg1_q};
            `OFS_SENS_CFG1: rdata_d = {24'h000000, sens_cfg1_q};
            `OFS_TEMP_CFG: rdata_d = {24'h000000, temp_cfg_q};
            `OFS_INT_CFG1: rdata_d = {24'h000000, int_cfg1_q};
            `OFS_DEV_CFG2: rdata_d = {24'h000000, dev_cfg2_q};
            `OFS_THR_X: rdata_d = {16'h0000, thr_q[0]};
            `OFS_THR_Y: rdata_d = {16'h0000, thr_q[1]};
            `OFS_THR_Z: rdata_d = {16'h0000, thr_q[2]};
            `OFS_STATUS: rdata_d = {24'h000000, 2'h0, inside_q, int_s2_q, busy_q, int_low_q};
            `OFS_RES_T: rdata_d = {16'h0000, res_q[0]};
            `OFS_RES_X: rdata_d = {16'h0000, res_q[1]};
            `OFS_RES_Y: rdata_d = {16'h0000, res_q[2]};
            `OFS_RES_Z: rdata_d = {16'h0000, res_q[3]};
            default: rdata_d = 32'h00000000;
        endcase
    end
    assign o_prdata = apb_rd_ack ? rdata_d : 32'h00000000;
    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;
endmodule

`default_nettype wire

// file: testbench/conv_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module conv_seq_sva #(
    parameter integer SAMPLE_CYC = 20,
    parameter integer WAKE_CYC = 50
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_int_in,
    input wire logic o_int_out,
    input wire logic o_int_oe,
    input wire logic o_sample_req,
    input wire logic [1:0] o_sample_ch,
    input wire logic i_sample_valid,
    input wire logic [15:0] i_sample_data
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire acc = i_psel && i_penable;
    wire wr = acc && i_pwrite;
    logic [3:0] chen_q;
    logic [1:0] mode_q;
    int pin_q;
    int idle_q;
    // mirrors of axis enable and mode; a wake-mode alarm drops to mode 0
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            chen_q <= 4'h0;
            mode_q <= 2'h0;
            pin_q <= 0;
            idle_q <= 0;
        end else begin
            if (wr && i_paddr == 8'h04) chen_q <= i_pwdata[7:4];
            if (wr && i_paddr == 8'h10) mode_q <= i_pwdata[1:0];
            else if (mode_q == 2'h3 && o_int_oe) mode_q <= 2'h0;
            pin_q <= o_int_oe ? pin_q + 1 : 0;
            idle_q <= (mode_q == 2'h3 && !o_sample_req) ? idle_q + 1 : 0;
        end
    end
    property p_out_low; o_int_out == 1'b0; endproperty
    a_out_low: assert property (p_out_low) else $error("pin driven high");
    property p_pin_len; $fell(o_int_oe) |-> pin_q == SAMPLE_CYC + 1; endproperty
    a_pin_len: assert property (p_pin_len) else $error("pin low time wrong");
    property p_hold; o_sample_req && !i_sample_valid |=> o_sample_req && $stable(o_sample_ch);
    endproperty
    a_hold: assert property (p_hold) else $error("sample request dropped");
    property p_xzx; chen_q == 4'hB && o_sample_req |-> o_sample_ch != 2'd2; endproperty
    a_xzx: assert property (p_xzx) else $error("y sampled in xzx order");
    property p_yzy; chen_q == 4'hC && o_sample_req |-> o_sample_ch != 2'd1; endproperty
    a_yzy: assert property (p_yzy) else $error("x sampled in yzy order");
    property p_trig;
        wr && i_paddr == 8'h20 && i_pwdata[0] && mode_q == 2'h0 && !o_sample_req
            |-> ##[1:40] o_sample_req;
    endproperty
    a_trig: assert property (p_trig) else $error("bus trigger not started");
    property p_wake; idle_q < WAKE_CYC + 20; endproperty
    a_wake: assert property (p_wake) else $error("no wake-up measurement");
    property p_rd_idle; !acc |-> o_prdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside access");
    property p_ready; acc |-> o_pready && !o_pslverr; endproperty
    a_ready: assert property (p_ready) else $error("bus answer wrong");
    property p_unmapped; acc && !i_pwrite && i_paddr > 8'h34 |-> o_prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// file: testbench/sample_src.sv
`timescale 1ns/1ps
`default_nettype none
module sample_src (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic [1:0] i_ch,
    input wire logic [63:0] i_vals,
    input wire logic i_slow,
    output logic o_valid,
    output logic [15:0] o_data
);
    logic [3:0] cnt_q;
    logic done_q;
    // one answer per request; data line toggles outside the pulse
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
            o_valid <= 1'b0;
            o_data <= 16'h0000;
        end else begin
            o_valid <= 1'b0;
            o_data <= ~o_data;
            cnt_q <= i_req ? cnt_q + 4'h1 : 4'h0;
            done_q <= i_req && done_q;
            if (i_req && !done_q && cnt_q == (i_slow ? 4'h7 : 4'h2)) begin
                o_valid <= 1'b1;
                o_data <= i_vals[16 * i_ch +: 16];
                done_q <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/hall_sensor_conversion_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "conv_seq_map.vh"
bind conv_seq conv_seq_sva #(.SAMPLE_CYC(SAMPLE_CYC), .WAKE_CYC(WAKE_CYC)) i_sva (.*);
module hall_sensor_conversion_sequencer_test;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic host_low = 1'b0, slow = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [63:0] vals = 64'h0444_0333_0222_0111;
    wire [31:0] rd;
    wire rdy, err, iout, ioe, req, sv;
    wire [1:0] ch;
    wire [15:0] sd;
    wire pin = ioe ? iout : !host_low;
    int fails = 0, num_checks = 0, pulses = 0, cyc = 0;
    logic [1:0] seq[$];
    int ts[$];
    conv_seq #(.WAKE_CYC(50)) i_dut (
        .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(addr), .i_pwdata(wd), .o_prdata(rd), .o_pready(rdy), .o_pslverr(err),
        .i_int_in(pin), .o_int_out(iout), .o_int_oe(ioe), .o_sample_req(req),
        .o_sample_ch(ch), .i_sample_valid(sv), .i_sample_data(sd)
    );
    sample_src i_src (
        .i_clk(clk), .i_rst(rst), .i_req(req), .i_ch(ch), .i_vals(vals), .i_slow(slow),
        .o_valid(sv), .o_data(sd)
    );
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (sv) begin
            seq.push_back(ch);
            ts.push_back(cyc);
        end
    end
    always @(posedge ioe) pulses++;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int t;
        t = 0;
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1 && t++ < 50);
        chk("pready", rdy, 1'b1);
        r = rd;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(n, r, e);
    endtask
    task automatic wpulse(input int n);
        int t;
        t = 0;
        while (pulses < n && t++ < 5000) @(posedge clk);
    endtask
    task automatic trig(input logic by_pin, input logic dup, input int n, input logic [7:0] e);
        int t;
        t = 0;
        seq.delete();
        ts.delete();
        if (by_pin) begin
            host_low <= 1'b1;
            repeat (4) @(posedge clk);
            host_low <= 1'b0;
        end else begin
            wr(`OFS_TRIG, 32'h1);
        end
        if (dup) wr(`OFS_TRIG, 32'h1);
        while (seq.size() < n && t++ < 3000) @(posedge clk);
        repeat (60) @(posedge clk);
        chk("sample_count", seq.size(), n);
        for (int i = 0; i < 4 && i < n; i++) chk("sample_order", seq[i], e[2 * i +: 2]);
    endtask
    task automatic end_sim;
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        fails++;
        end_sim();
    end
    initial begin
        logic [31:0] r;
        logic [15:0] v;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 8; a++) rc("reset_value", 8'(4 * a), 32'h0);
        wr(8'h3C, 32'hFFFF_FFFF);
        rc("unmapped", 8'h3C, 32'h0);
        slow <= 1'b1;
        wr(`OFS_TEMP_CFG, 32'h1);
        wr(`OFS_SENS_CFG1, 32'h70);
        trig(1'b0, 1'b1, 4, 8'hE4);
        for (int i = 0; i < 4; i++) rc("result", 8'h28 + 8'(4 * i), {16'h0, vals[16 * i +: 16]});
        slow <= 1'b0;
        wr(`OFS_SENS_CFG1, 32'hB0);
        trig(1'b1, 1'b0, 4, 8'h74);
        chk("midpoint", ts[2] - ts[1], ts[3] - ts[2]);
        wr(`OFS_SENS_CFG1, 32'hC0);
        trig(1'b0, 1'b0, 4, 8'hB8);
        wr(`OFS_TEMP_CFG, 32'h0);
        wr(`OFS_SENS_CFG1, 32'h10);
        wr(`OFS_DEV_CFG1, 32'h14);
        trig(1'b0, 1'b0, 32, 8'h55);
        rc("avg_x", `OFS_RES_X, 32'h0222);
        wr(`OFS_DEV_CFG1, 32'h0);
        wr(`OFS_SENS_CFG1, 32'h50);
        for (int i = 0; i < 3; i++) wr(`OFS_THR_X + 8'(4 * i), 32'd100);
        for (int m = 0; m < 8; m++) begin
            wr(`OFS_INT_CFG1, {24'h0, 4'h4, m[0], m[1], 2'b00});
            v = (m[0] == m[2]) ? 16'd50 : 16'd200;
            vals <= {v, 16'h0, v, 16'h0};
            pulses = 0;
            trig(1'b0, 1'b0, 2, 8'h0D);
            chk("limit_int", pulses, m[2]);
        end
        trig(1'b0, 1'b0, 2, 8'h0D);
        chk("repeat_int", pulses, 2);
        wr(`OFS_INT_CFG1, 32'h40);
        vals <= {16'd200, 16'h0, 16'd50, 16'h0};
        pulses = 0;
        trig(1'b0, 1'b0, 2, 8'h0D);
        chk("z_only_int", pulses, 1);
        slow <= 1'b1;
        vals <= 64'h0444_0333_0222_0111;
        wr(`OFS_DEV_CFG1, 32'h1);
        wr(`OFS_SENS_CFG1, 32'h79);
        wr(`OFS_TEMP_CFG, 32'h1);
        wr(`OFS_INT_CFG1, 32'hA4);
        seq.delete();
        pulses = 0;
        wr(`OFS_DEV_CFG2, 32'h22);
        wpulse(1);
        chk("pin_low", pin, 1'b0);
        for (int i = 0; i < 4; i++) rc("result", 8'h28 + 8'(4 * i), {16'h0, vals[16 * i +: 16]});
        wpulse(2);
        chk("cont_ints", pulses >= 2, 1'b1);
        chk("temp_first", seq[4], 2'd0);
        vals <= 64'h0010_0010_0010_0111;
        repeat (100) @(posedge clk);
        wr(`OFS_INT_CFG1, 32'h64);
        seq.delete();
        wr(`OFS_DEV_CFG2, 32'h23);
        pulses = 0;
        repeat (400) @(posedge clk);
        chk("wake_rounds", seq.size() >= 8, 1'b1);
        chk("no_tamper_int", pulses, 0);
        vals <= 64'h0010_0010_0200_0111;
        wpulse(1);
        chk("tamper_int", pulses, 1);
        apb(1'b0, `OFS_DEV_CFG2, 32'h0, r);
        chk("mode_left", r[1:0], 2'h0);
        repeat (40) @(posedge clk);
        seq.delete();
        repeat (300) @(posedge clk);
        chk("asleep", seq.size(), 0);
        end_sim();
    end
endmodule
`default_nettype wire
